// [logic/pcg_pkg.sv]
// Constants for the clock generator: register map, field layout, reset
// values and the timing counts derived from the 50 MHz aclk.
package pcg_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] ADDR_CSR    = 8'h00;
  localparam logic [7:0] ADDR_MULT   = 8'h10;
  localparam logic [7:0] ADDR_DIV0   = 8'h14;
  localparam logic [7:0] ADDR_AUX    = 8'h24;
  localparam logic [7:0] ADDR_DEVICE_CONFIG_REG = 8'h28;
  localparam logic [7:0] ADDR_MEM_IF_GLOBAL_CTL = 8'h2C;

  // Word indices (byte offset / 4)
  localparam int IDX_CSR    = 0;
  localparam int IDX_MULT   = 4;
  localparam int IDX_DIV0   = 5;
  localparam int IDX_AUX    = 9;
  localparam int IDX_DEVICE_CONFIG_REG = 10;
  localparam int IDX_MEM_IF_GLOBAL_CTL = 11;
  localparam logic [15:0] MAP_VALID = 16'h0FF1;

  // Field positions
  localparam int CSR_PATH_BIT   = 0;
  localparam int CSR_PWRDN_BIT  = 1;
  localparam int CSR_RST_BIT    = 3;
  localparam int CSR_STABLE_BIT = 6;
  localparam int DIV_EN_BIT     = 15;
  localparam int DEVICE_CONFIG_REG_SRC_BIT = 4;
  localparam int GBL_CK2_BIT    = 3;
  localparam int GBL_MEM_CLK_PIN_ENABLE_BIT   = 5;

  // Divider slots: 0 prescaler, 1 core, 2 periph, 3 mem, 4 aux
  localparam int NDIV = 5;
  localparam logic [4:0] DIV_RATIO_RST [NDIV] =
    '{5'h00, 5'h00, 5'h01, 5'h01, 5'h00};
  localparam logic       DIV_EN_RST  = 1'b1;
  localparam logic [4:0] MULT_RST    = 5'h07;
  localparam logic [4:0] MULT_MIN    = 5'h04;
  localparam logic [4:0] MULT_MAX    = 5'h19;
  localparam logic [4:0] NCO_DEN_LOG = 5'h05;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int  CLK_PERIOD_NS  = 20;
  localparam real CLK_MHZ        = 50.0;
  localparam int  PLL_RST_TIME_NS = 125;
  localparam int  PLL_RST_CYCLES =
    (PLL_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real PLL_LOCK_TIME_US = 187.5;
  localparam int  PLL_LOCK_CYCLES = int'($ceil(PLL_LOCK_TIME_US * CLK_MHZ));

endpackage

// [logic/pcg_clk_div.sv]
// Glitch-free integer clock divider driven by a reference tick.
// Assumes tick is a one-cycle strobe in the aclk domain.
`timescale 1ns/100ps
module pcg_clk_div
  import pcg_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       tick,
  input  wire logic [4:0] ratio,
  input  wire logic       enable,
  output logic            clk_out
);

  logic [4:0] cnt_r;
  logic [4:0] cur_r;
  logic       run_r;
  logic       wrap_w;

  assign wrap_w = (cnt_r == cur_r);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r   <= 5'h00;
      cur_r   <= 5'h00;
      run_r   <= 1'b0;
      clk_out <= 1'b0;
    end else if (!run_r) begin
      // Idle low; load settings before starting a period
      cnt_r   <= 5'h00;
      cur_r   <= ratio;
      run_r   <= enable;
      clk_out <= 1'b0;
    end else if (tick) begin
      if (wrap_w) begin
        cnt_r   <= 5'h00;
        clk_out <= ~clk_out;
        // New ratio or enable only at a full period end
        if (clk_out) begin
          cur_r <= ratio;
          run_r <= enable;
        end
      end else begin
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

endmodule

// [logic/pcg_top.sv]
// Clock generator: prescaler, PLL model, bypass select, output dividers,
// clock pin gating and an AXI4-Lite register slave.
// Assumes all inputs are synchronous to aclk.
// What this block does
// - Provides a prescaler plus aux, core, periph-bus and mem-if dividers.
// - Second pin carries periph clock, gated by divider and pin enables.
// - Third pin carries aux-divided input clock, gated by aux enable.
// - Mem clock pin picks internal or external clock, gated by its enable.
// - Aux divider divides raw input clock by 2 to 64 in steps of 2.
// - Prescaler divides by 1 to 32; PLL multiplies by 4 to 25.
// - Path select 0 uses input clock, 1 uses PLL output as reference.
// - Core, periph and mem clocks each have their own divider.
// - After reset the PLL is held in reset and bypass is selected.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module pcg_top
  import pcg_pkg::*;
#(
  parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        mem_clk_in_pin,
  output logic             core_clk,
  output logic             periph_bus_clk,
  output logic             mem_if_clk,
  output logic             second_clk_pin,
  output logic             third_clk_pin,
  output logic             mem_clk_out_pin
);
  // Control registers
  logic        pll_path_select_r;
  logic        pll_pwrdn_r;
  logic        pll_reset_ctl_r;
  logic [4:0]  mult_r;
  logic [4:0]  ratio_r [NDIV];
  logic        en_r    [NDIV];
  logic        mem_clk_source_sel_r;
  logic        second_clk_pin_enable_r;
  logic        mem_clk_pin_enable_r;
  // PLL state
  logic        pll_held_r;
  logic [3:0]  rst_cnt_r;
  logic [15:0] lock_cnt_r;
  logic [10:0] acc_r;
  // AXI state
  logic        aw_hold_r;
  logic [7:0]  awaddr_r;
  logic        w_hold_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  // Decode and data path wires
  logic [31:0] word_w [16];
  logic        aw_take_w;
  logic        w_take_w;
  logic        ar_take_w;
  logic        do_write_w;
  logic        aw_hold_nxt;
  logic        w_hold_nxt;
  logic        bvalid_nxt;
  logic        rvalid_nxt;
  logic [3:0]  widx_w;
  logic [3:0]  ridx_w;
  logic        wmapped_w;
  logic        rmapped_w;
  logic [31:0] wmask_w;
  logic [31:0] merged_w;
  logic [15:0] wr_sel_w;
  logic        pll_stable_w;
  logic        pll_run_w;
  logic        rst_done_w;
  logic [4:0]  mult_eff_w;
  logic [10:0] thr_w;
  logic [10:0] acc_sum_w;
  logic        pll_tick_w;
  logic        ref_tick_w;
  logic        div_clk_w [NDIV];
  // Readback words
  assign word_w[IDX_CSR] = {25'h000_0000, pll_stable_w, 2'b00,
                            pll_reset_ctl_r, 1'b0, pll_pwrdn_r,
                            pll_path_select_r};
  assign word_w[IDX_MULT]   = {27'h000_0000, mult_r};
  assign word_w[IDX_DEVICE_CONFIG_REG] = {27'h000_0000, mem_clk_source_sel_r, 4'h0};
  assign word_w[IDX_MEM_IF_GLOBAL_CTL] = {26'h000_0000, mem_clk_pin_enable_r, 1'b0,
                               second_clk_pin_enable_r, 3'h0};
  // AXI handshake decode
  assign aw_take_w   = s_axi_awvalid && s_axi_awready;
  assign w_take_w    = s_axi_wvalid && s_axi_wready;
  assign ar_take_w   = s_axi_arvalid && s_axi_arready;
  assign do_write_w  = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign aw_hold_nxt = do_write_w ? 1'b0 : (aw_hold_r || aw_take_w);
  assign w_hold_nxt  = do_write_w ? 1'b0 : (w_hold_r || w_take_w);
  assign bvalid_nxt  = do_write_w || (s_axi_bvalid && !s_axi_bready);
  assign rvalid_nxt  = ar_take_w || (s_axi_rvalid && !s_axi_rready);
  assign widx_w      = awaddr_r[5:2];
  assign ridx_w      = s_axi_araddr[5:2];
  assign wmapped_w   = (awaddr_r[7:6] == 2'b00) && MAP_VALID[widx_w];
  assign rmapped_w   = (s_axi_araddr[7:6] == 2'b00) && MAP_VALID[ridx_w];
  assign wmask_w     = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                        {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign merged_w    = (word_w[widx_w] & ~wmask_w) | (wdata_r & wmask_w);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_hold_r     <= aw_hold_nxt;
      w_hold_r      <= w_hold_nxt;
      s_axi_awready <= !aw_hold_nxt;
      s_axi_wready  <= !w_hold_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      if (aw_take_w) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_take_w) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write_w) begin
        s_axi_bresp <= wmapped_w ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (ar_take_w) begin
        s_axi_rdata <= rmapped_w ? word_w[ridx_w] : 32'h0000_0000;
        s_axi_rresp <= rmapped_w ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  // Control register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_path_select_r       <= 1'b0;
      pll_pwrdn_r             <= 1'b0;
      pll_reset_ctl_r         <= 1'b1;
      mult_r                  <= MULT_RST;
      mem_clk_source_sel_r    <= 1'b0;
      second_clk_pin_enable_r <= 1'b1;
      mem_clk_pin_enable_r    <= 1'b1;
    end else begin
      if (wr_sel_w[IDX_CSR]) begin
        pll_path_select_r <= merged_w[CSR_PATH_BIT];
        pll_pwrdn_r       <= merged_w[CSR_PWRDN_BIT];
        pll_reset_ctl_r   <= merged_w[CSR_RST_BIT];
      end
      if (wr_sel_w[IDX_MULT]) begin
        mult_r <= merged_w[4:0];
      end
      if (wr_sel_w[IDX_DEVICE_CONFIG_REG]) begin
        mem_clk_source_sel_r <= merged_w[DEVICE_CONFIG_REG_SRC_BIT];
      end
      if (wr_sel_w[IDX_MEM_IF_GLOBAL_CTL]) begin
        second_clk_pin_enable_r <= merged_w[GBL_CK2_BIT];
        mem_clk_pin_enable_r    <= merged_w[GBL_MEM_CLK_PIN_ENABLE_BIT];
      end
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_wsel
      assign wr_sel_w[gi] = do_write_w && wmapped_w && (widx_w == gi);
      if (!MAP_VALID[gi]) begin : g_rsv
        assign word_w[gi] = 32'h0000_0000;
      end
    end
    // Divider ratio registers, each its own word
    for (gi = 0; gi < NDIV; gi++) begin : g_div
      assign word_w[IDX_DIV0 + gi] = {16'h0000, en_r[gi], 10'h000,
                                      ratio_r[gi]};
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ratio_r[gi] <= DIV_RATIO_RST[gi];
          en_r[gi]    <= DIV_EN_RST;
        end else if (wr_sel_w[IDX_DIV0 + gi]) begin
          ratio_r[gi] <= merged_w[4:0];
          en_r[gi]    <= merged_w[DIV_EN_BIT];
        end
      end
    end
    // Output dividers; the aux one runs off the raw input clock
    for (gi = 1; gi < NDIV; gi++) begin : g_out
      pcg_clk_div u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    ((gi == NDIV - 1) ? 1'b1 : ref_tick_w),
        .ratio   (ratio_r[gi]),
        .enable  (en_r[gi]),
        .clk_out (div_clk_w[gi])
      );
    end
  endgenerate
  assign div_clk_w[0] = 1'b0;
  // PLL reset is stretched to the minimum reset time
  assign rst_done_w = (rst_cnt_r >= 4'(PLL_RST_CYCLES));
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_held_r <= 1'b1;
      rst_cnt_r  <= 4'h0;
    end else if (pll_reset_ctl_r) begin
      pll_held_r <= 1'b1;
      if (!rst_done_w) begin
        rst_cnt_r <= rst_cnt_r + 4'h1;
      end
    end else if (pll_held_r && rst_done_w) begin
      pll_held_r <= 1'b0;
      rst_cnt_r  <= 4'h0;
    end else if (pll_held_r) begin
      rst_cnt_r <= rst_cnt_r + 4'h1;
    end
  end
  // Lock counter; stable flag tells software bypass may be left
  assign pll_run_w    = !pll_held_r && !pll_pwrdn_r;
  assign pll_stable_w = (lock_cnt_r == 16'(LOCK_CYCLES));
  always_ff @(posedge aclk) begin
    if (!aresetn || !pll_run_w) begin
      lock_cnt_r <= 16'h0000;
    end else if (!pll_stable_w) begin
      lock_cnt_r <= lock_cnt_r + 16'h0001;
    end
  end
  // Prescale and multiply as a phase accumulator, 4..25 clamp
  assign mult_eff_w = (mult_r < MULT_MIN) ? MULT_MIN :
                      (mult_r > MULT_MAX) ? MULT_MAX : mult_r;
  assign thr_w      = 11'({1'b0, ratio_r[0]} + 6'h01) << NCO_DEN_LOG;
  assign acc_sum_w  = acc_r + {6'h00, mult_eff_w};
  assign pll_tick_w = pll_run_w && en_r[0] && (acc_sum_w >= thr_w);
  always_ff @(posedge aclk) begin
    if (!aresetn || !pll_run_w || !en_r[0]) begin
      acc_r <= 11'h000;
    end else if (acc_sum_w >= thr_w) begin
      acc_r <= acc_sum_w - thr_w;
    end else begin
      acc_r <= acc_sum_w;
    end
  end
  // Reference select; dividers only change at period ends
  assign ref_tick_w = pll_path_select_r ? pll_tick_w : 1'b1;
  assign core_clk       = div_clk_w[1];
  assign periph_bus_clk = div_clk_w[2];
  assign mem_if_clk     = div_clk_w[3];
  // Clock pin gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_clk_pin  <= 1'b0;
      third_clk_pin   <= 1'b0;
      mem_clk_out_pin <= 1'b0;
    end else begin
      second_clk_pin  <= div_clk_w[2] && en_r[2] &&
                         second_clk_pin_enable_r;
      third_clk_pin   <= div_clk_w[4] && en_r[4];
      mem_clk_out_pin <= mem_clk_pin_enable_r &&
                         (mem_clk_source_sel_r ? mem_clk_in_pin
                                               : div_clk_w[3]);
    end
  end
endmodule

// [dv/pcg_monitor.sv]
// Checker for the clock generator, watching pcg_top ports only.
// Assumes one aclk domain with a synchronous active-low reset.
`timescale 1ns/100ps
module pcg_monitor
  import pcg_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        core_clk,
  input wire logic        periph_bus_clk,
  input wire logic        mem_if_clk,
  input wire logic        second_clk_pin,
  input wire logic        third_clk_pin,
  input wire logic        mem_clk_in_pin,
  input wire logic        mem_clk_out_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [6:0] hi_run_r;
  wire        ar_take = s_axi_arvalid && s_axi_arready;
  wire        ar_bad  = s_axi_araddr[7:6] != 2'h0
                        || !MAP_VALID[s_axi_araddr[5:2]];
  // Length of the current high phase of the third pin
  always_ff @(posedge aclk) begin
    if (!aresetn || !third_clk_pin) hi_run_r <= 7'h00;
    else if (hi_run_r != 7'h7F) hi_run_r <= hi_run_r + 7'h01;
  end
  property p_reset_quiet;
    $rose(aresetn) |-> !core_clk && !periph_bus_clk && !mem_if_clk
      && !third_clk_pin && !s_axi_rvalid && !s_axi_bvalid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active at reset release");
  property p_second_pin;
    second_clk_pin |-> $past(periph_bus_clk);
  endproperty
  a_second_pin: assert property (p_second_pin)
    else $error("second pin high without peripheral clock");
  property p_mem_pin;
    mem_clk_out_pin |-> $past(mem_if_clk) || $past(mem_clk_in_pin)
      || $past(mem_clk_in_pin, 2) || $past(mem_clk_in_pin, 3);
  endproperty
  a_mem_pin: assert property (p_mem_pin)
    else $error("memory clock pin high without a source");
  property p_aux_run;
    hi_run_r <= 7'h20;
  endproperty
  a_aux_run: assert property (p_aux_run)
    else $error("third pin high longer than 32 cycles");
  property p_w_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid |-> ##2 s_axi_bvalid;
  endproperty
  a_w_resp: assert property (p_w_resp)
    else $error("write response late");
  property p_r_resp;
    ar_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r_resp: assert property (p_r_resp)
    else $error("read data late");
  property p_r_bad;
    ar_take && ar_bad |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_r_bad: assert property (p_r_bad)
    else $error("unmapped read not refused");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read data held after handshake");
endmodule

bind pcg_top pcg_monitor u_mon (
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .core_clk, .periph_bus_clk, .mem_if_clk,
  .second_clk_pin, .third_clk_pin, .mem_clk_in_pin, .mem_clk_out_pin
);

// [dv/tb.sv]
// Self-checking bench for the clock generator.
// Assumes the monitor is bound to pcg_top.
`timescale 1ns/100ps
module tb
  import pcg_pkg::*;
;
  localparam int         LOCK = 20;
  localparam logic [7:0] RA [10] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18,
                                     8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  localparam logic [15:0] RV [10] = '{16'h0008, 16'h0000, 16'h0007,
    16'h8000, 16'h8000, 16'h8001, 16'h8001, 16'h8000, 16'h0000, 16'h0028};
  localparam int DP [6] = '{2, 4, 4, 4, 2, 4};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, mem_clk_in_pin;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, mem_div_r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, core_clk, periph_bus_clk, mem_if_clk;
  logic        second_clk_pin, third_clk_pin, mem_clk_out_pin;
  logic [31:0] seed = 32'h0001_68E6;
  int          n_fail = 0;
  int          n_compared = 0;
  wire  [5:0]  clks = {mem_clk_out_pin, third_clk_pin, second_clk_pin,
                       mem_if_clk, periph_bus_clk, core_clk};

  pcg_top #(.LOCK_CYCLES(LOCK)) DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mem_clk_in_pin, .core_clk, .periph_bus_clk, .mem_if_clk,
    .second_clk_pin, .third_clk_pin, .mem_clk_out_pin
  );

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // External memory clock, period of six cycles
  always @(posedge aclk) begin
    mem_div_r <= (mem_div_r == 2'h2) ? 2'h0 : mem_div_r + 2'h1;
    if (mem_div_r == 2'h2) mem_clk_in_pin <= !mem_clk_in_pin;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_per(int r, int m, int pre, bit pll);
    int me;
    me = m < 4 ? 4 : (m > 25 ? 25 : m);
    return pll ? 2 * (r + 1) * 32 * (pre + 1) / me : 2 * (r + 1);
  endfunction
  function automatic logic [31:0] dv(logic [4:0] r);
    return {16'h0000, 1'b1, 10'h000, r};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s,
                    logic [1:0] er);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      t++;
    end while (!s_axi_bvalid && t < 200);
    chk("bvalid", 32'h0000_0001, {31'h0, s_axi_bvalid});
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic wd(logic [7:0] a, logic [4:0] r);
    wr(a, dv(r), 4'hF, RESP_OKAY);
  endtask
  task automatic rchk(logic [7:0] a, logic [31:0] e, logic [1:0] er);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      t++;
    end while (!s_axi_rvalid && t < 200);
    chk("rvalid", 32'h0000_0001, {31'h0, s_axi_rvalid});
    chk("rdata", e, s_axi_rdata);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // Cycles between two rising edges of one clock output, 0 if none
  task automatic pc(int i, int ex);
    int t, e, p;
    logic q;
    t = 0;
    e = 0;
    p = 0;
    q = 1'b1;
    while (e < 2 && t < (ex == 0 ? 200 : 4000)) begin
      @(negedge aclk);
      if (clks[i] === 1'b1 && q === 1'b0) e++;
      if (e == 1) p++;
      q = clks[i];
      t++;
    end
    chk($sformatf("period %0d", i), ex, p);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    settle(80000);
    n_fail++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    logic [4:0]  rc, rp, rm, ra, oc;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_bready, s_axi_rready, mem_clk_in_pin, mem_div_r} = 5'h18;
    settle(4);
    aresetn <= 1'b1;
    settle(2);
    for (int k = 0; k < 10; k++)
      rchk(RA[k], {16'h0, RV[k]}, k == 1 ? RESP_SLVERR : RESP_OKAY);
    for (int k = 0; k < 6; k++) pc(k, DP[k]);
    oc = 5'h00;
    for (int k = 0; k < 6; k++) begin
      d = rnd();
      rc = k == 0 ? 5'h0F : {1'b0, d[3:0]};
      rp = {rc[3:0], 1'b1};
      rm = k == 0 ? 5'h00 : d[8:4];
      ra = k == 0 ? 5'h1F : d[13:9];
      if (rc > oc) begin
        wd(8'h1C, rp);
        wd(8'h18, rc);
      end else begin
        wd(8'h18, rc);
        wd(8'h1C, rp);
      end
      wd(8'h20, rm);
      wd(8'h24, ra);
      oc = rc;
      settle(300);
      pc(0, exp_per(rc, 0, 0, 0));
      pc(1, exp_per(rp, 0, 0, 0));
      pc(2, exp_per(rm, 0, 0, 0));
      pc(3, exp_per(rp, 0, 0, 0));
      pc(4, exp_per(ra, 0, 0, 0));
      pc(5, exp_per(rm, 0, 0, 0));
    end
    wr(8'h24, 32'h0000_0002, 4'h1, RESP_OKAY);
    settle(100);
    pc(4, 6);
    wr(8'h24, 32'h0000_0000, 4'h2, RESP_OKAY);
    settle(100);
    pc(4, 0);
    wr(8'h3C, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    wr(ADDR_MEM_IF_GLOBAL_CTL, 32'h0000_0020, 4'hF, RESP_OKAY);
    settle(100);
    pc(3, 0);
    wr(ADDR_DEVICE_CONFIG_REG, 32'h0000_0010, 4'hF, RESP_OKAY);
    settle(100);
    pc(5, 6);
    wr(ADDR_MEM_IF_GLOBAL_CTL, 32'h0000_0008, 4'hF, RESP_OKAY);
    settle(100);
    pc(5, 0);
    pc(3, exp_per(rp, 0, 0, 0));
    wr(ADDR_CSR, 32'h0000_0008, 4'hF, RESP_OKAY);
    settle(8);
    wr(ADDR_CSR, 32'h0000_0000, 4'hF, RESP_OKAY);
    rchk(ADDR_CSR, 32'h0000_0000, RESP_OKAY);
    settle(LOCK + 10);
    rchk(ADDR_CSR, 32'h0000_0040, RESP_OKAY);
    wr(ADDR_CSR, 32'h0000_0002, 4'hF, RESP_OKAY);
    rchk(ADDR_CSR, 32'h0000_0002, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CSR, 32'h0000_0000, 4'hF, RESP_OKAY);
      wr(ADDR_MULT, k ? 32'h0000_0008 : 32'h0000_0002, 4'hF, RESP_OKAY);
      wd(ADDR_DIV0, k[4:0]);
      wr(ADDR_CSR, 32'h0000_0001, 4'hF, RESP_OKAY);
      settle(600);
      pc(0, exp_per(oc, k ? 8 : 2, k, 1));
    end
    wr(ADDR_CSR, 32'h0000_0000, 4'hF, RESP_OKAY);
    settle(100);
    pc(0, exp_per(oc, 0, 0, 0));
    @(posedge aclk);
    aresetn <= 1'b0;
    settle(2);
    aresetn <= 1'b1;
    settle(2);
    rchk(ADDR_CSR, 32'h0000_0008, RESP_OKAY);
    close_out();
  end
endmodule
